// File: hdl/pes_elastic_store.sv
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "pes_defs.svh"
// Overview of operation
// - 9-bit line counter, preset by preset input
// - counter decode gives slip timing, inserter enables
// - counter steers store write strobes and guards
// - all 32 channel words retimed to exchange side
// - channel number carried, 5-bit parallel output
// - slip decided by guards against read reference
// - 4-bit read counter gives reference, eight strobes
// - slip repeats or skips channel 0, two frames
// - normal slip restores nominal store separation
// - other channels pass unchanged during slips
// - forced slip acts for one frame only
// - alignment frame bits 3-8 take spares 1-6
// - non-alignment: bit2 one, spare 7, slip flag
// - master reset inits slip and read timing
// - channel number changes on read clock fall
// - serial data changes on exchange clock rise
// - alignment frame keeps only bits 1-2 of the line word
module pes_elastic_store #(
  parameter int PTR_W = 3
) (
  // system
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  // apb slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // line side
  input  wire logic        line_clock_in,
  input  wire logic        line_data_in,
  input  wire logic        line_counter_preset_in,
  // exchange side
  input  wire logic        exchange_clock_in,
  input  wire logic        read_clock_in,
  input  wire logic        master_reset_n_in,
  input  wire logic        forced_slip_in,
  input  wire logic [6:0]  spare_bit_inputs_in,
  output logic             serial_data_out,
  output logic [4:0]       channel_number_out,
  // interrupt
  output logic             irq_out
);
  import pes_pkg::*;

  // depth 8: a slip moves two entries, so guards need two of margin each way
  localparam int DEPTH = 1 << PTR_W;
  localparam int SW    = 14;

  // raw pin inputs, all foreign to clock_in
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_q;  // first stage, read only by s2
  logic [SW-1:0] s2_q;  // synchronised
  logic [SW-1:0] s3_q;  // previous, for edges
  assign raw = {spare_bit_inputs_in, forced_slip_in, master_reset_n_in,
                exchange_clock_in, read_clock_in, line_counter_preset_in,
                line_data_in, line_clock_in};

  // two-flop synchroniser plus edge history
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edges and levels on the synchronised side
  logic lc_rise, rc_rise, rc_fall, ce_rise, frc_rise;
  logic din, preset, mr_n, rd_rst;
  logic [6:0] sp;
  assign lc_rise  = s2_q[0] & ~s3_q[0];
  assign din      = s2_q[1];
  assign preset   = s2_q[2];
  assign rc_rise  = s2_q[3] & ~s3_q[3];
  assign rc_fall  = ~s2_q[3] & s3_q[3];
  assign ce_rise  = s2_q[4] & ~s3_q[4];
  assign mr_n     = s2_q[5];
  assign frc_rise = s2_q[6] & ~s3_q[6];
  assign sp       = s2_q[13:7];
  // master reset covers slip control and read timing
  assign rd_rst   = sys_rst_in | ~mr_n;

  // line timing counter
  logic [8:0] lcnt_q;
  logic [8:0] lcnt_d;
  always_comb begin
    if (preset) lcnt_d = `PES_LINE_PRESET;
    else        lcnt_d = 9'(lcnt_q + 9'h001);
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) lcnt_q <= '0;
    else if (lc_rise) lcnt_q <= lcnt_d;
  end

  // serial-to-word shifter on the line clock
  logic [6:0] wsh_q;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) wsh_q <= '0;
    else if (lc_rise) wsh_q <= {wsh_q[5:0], din};
  end

  // counter decode: word end, slot, frame
  logic       wdone, wch0, wframe;
  logic [4:0] wch;
  pes_entry_t went;
  assign wch    = lcnt_d[7:3];
  assign wframe = lcnt_d[8];  // low is the alignment frame
  assign wdone  = lc_rise & (lcnt_d[2:0] == 3'h7);  // whole words only
  assign wch0   = wdone & (wch == 5'h00);  // slip command timing
  // inserter enables travel with the word
  assign went = {wch0 & wframe, wch0 & ~wframe, wch, wsh_q, din};

  // store pointers; occupancy is the guard measure
  logic [PTR_W:0] wr_ptr_q, rd_ptr_q, occ;
  assign occ = (PTR_W+1)'(wr_ptr_q - rd_ptr_q);

  // slip controller state
  pes_slip_e pend_q;
  pes_slip_e act;
  logic      force_q, fused, slip_ind_q;

  // slip decision at each channel 0 write
  always_comb begin
    act   = slip_none;
    fused = 1'b0;
    if (wch0) begin
      if (pend_q != slip_none) begin
        act = pend_q;  // second frame of slip
      end else if (occ >= `PES_GUARD_HI) begin
        act = slip_skip;  // write near read, jump
      end else if (occ <= `PES_GUARD_LO) begin
        act = slip_repeat;  // read near write, repeat
      end else if (force_q) begin
        fused = 1'b1;
        act   = (occ >= `PES_NOMINAL) ? slip_skip : slip_repeat;
      end
    end
  end

  // pending second frame; forced slips never pend
  always_ff @(posedge clock_in) begin
    if (rd_rst) begin
      pend_q <= slip_none;
    end else if (wch0) begin
      if (pend_q == slip_none && !fused) pend_q <= act;
      else pend_q <= slip_none;
    end
  end

  // ctrl write pulse from the bus
  logic wr_ctrl_force;

  // forced request held until a channel 0 uses it
  always_ff @(posedge clock_in) begin
    if (rd_rst) force_q <= 1'b0;
    else force_q <= frc_rise | wr_ctrl_force | (force_q & ~fused);
  end

  // write pointer: +1 normal, +2 repeat, hold on skip
  always_ff @(posedge clock_in) begin
    if (rd_rst) begin
      wr_ptr_q <= (PTR_W+1)'(`PES_NOMINAL);  // nominal margin
    end else if (wdone) begin
      case (act)
        slip_repeat: wr_ptr_q <= (PTR_W+1)'(wr_ptr_q + 2'd2);
        slip_skip:   wr_ptr_q <= wr_ptr_q;
        default:     wr_ptr_q <= (PTR_W+1)'(wr_ptr_q + 2'd1);
      endcase
    end
  end

  // the store itself, one entry per slot
  pes_entry_t store_q [DEPTH];
  logic [DEPTH-1:0] we, rstb;

  // per entry write and read strobes
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    assign we[i] = wdone &&
      ((act != slip_skip && wr_ptr_q[PTR_W-1:0] == PTR_W'(i)) ||
       (act == slip_repeat &&
        PTR_W'(wr_ptr_q[PTR_W-1:0] + 1'b1) == PTR_W'(i)));
    assign rstb[i] = (rd_ptr_q[PTR_W-1:0] == PTR_W'(i));
    // data and channel number stored together
    always_ff @(posedge clock_in) begin
      if (we[i]) store_q[i] <= went;
    end
  end

  // read mux gated by the read strobes
  pes_entry_t rent;
  always_comb begin
    rent = '0;
    for (int k = 0; k < DEPTH; k++) begin
      rent = rent | (store_q[k] & {15{rstb[k]}});
    end
  end

  // slot 0 inserter on the read word
  logic [7:0] ins;
  always_comb begin
    ins = rent[7:0];
    if (rent[`PES_E_INSA]) begin
      ins[5:0] = {sp[0], sp[1], sp[2], sp[3], sp[4], sp[5]};
    end
    if (rent[`PES_E_INSB]) begin
      ins[6] = 1'b1;
      ins[5] = sp[6];
      ins[4] = slip_ind_q;
    end
  end

  // read counter; empty store rereads, never skips
  always_ff @(posedge clock_in) begin
    if (rd_rst) rd_ptr_q <= '0;
    else if (rc_rise && occ != '0) rd_ptr_q <= (PTR_W+1)'(rd_ptr_q + 1'b1);
  end

  // slip flag: set by a slip, cleared once sent
  always_ff @(posedge clock_in) begin
    if (rd_rst) slip_ind_q <= 1'b0;
    else if (act != slip_none) slip_ind_q <= 1'b1;  // set wins
    else if (rc_rise && rent[`PES_E_INSB]) slip_ind_q <= 1'b0;
  end

  // output word staging and serial shifter
  logic [7:0] word_q, sh_q;
  logic       ld_q, dout_q;
  logic [4:0] num_pend_q, num_q;
  always_ff @(posedge clock_in) begin
    if (rd_rst) begin
      word_q <= '0;
      sh_q   <= '0;
      ld_q   <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      if (ce_rise) begin
        if (ld_q) begin
          dout_q <= word_q[7];
          sh_q   <= {word_q[6:0], 1'b0};
          ld_q   <= 1'b0;
        end else begin
          dout_q <= sh_q[7];
          sh_q   <= {sh_q[6:0], 1'b0};
        end
      end
      // a new word waits for the next exchange edge
      if (rc_rise) begin
        word_q <= ins;
        ld_q   <= 1'b1;
      end
    end
  end

  // channel number: latched on rise, shown on fall
  always_ff @(posedge clock_in) begin
    if (rd_rst) begin
      num_pend_q <= '0;
      num_q      <= '0;
    end else begin
      if (rc_rise) num_pend_q <= rent[12:8];
      if (rc_fall) num_q <= num_pend_q;
    end
  end

  // apb: one wait state, answers from flops
  logic        pready_q, pslverr_q, acc_wr;
  logic [31:0] prdata_q;
  logic [2:0]  stat_q, mask_q, ev;
  logic        irq_q;
  assign acc_wr = psel_in & penable_in & pready_q & pwrite_in;
  assign wr_ctrl_force = acc_wr & (paddr_in == `PES_CTRL_OFS) &
                         pwdata_in[`PES_CTRL_FORCE];

  // read data and error captured in the first access cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= psel_in & penable_in & ~pready_q;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
      if (psel_in && penable_in && !pready_q) begin
        case (paddr_in)
          `PES_CTRL_OFS: prdata_q <= '0;
          `PES_STAT_OFS: prdata_q <= {29'h0, stat_q};
          `PES_MASK_OFS: prdata_q <= {29'h0, mask_q};
          `PES_STATE_OFS: begin
            prdata_q[`PES_SR_OCC +: 4]  <= 4'(occ);
            prdata_q[`PES_SR_SLIP]      <= slip_ind_q;
            prdata_q[`PES_SR_PEND +: 2] <= pend_q;
            prdata_q[`PES_SR_LCNT +: 9] <= lcnt_q;
          end
          default: pslverr_q <= 1'b1;  // unmapped
        endcase
      end
    end
  end

  // mask register steers the interrupt line
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) mask_q <= `PES_MASK_RST;
    else if (acc_wr && paddr_in == `PES_MASK_OFS) mask_q <= pwdata_in[2:0];
  end

  // sticky events, write one to clear, set wins
  assign ev = {fused, act == slip_skip, act == slip_repeat};
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) stat_q <= '0;
    else if (acc_wr && paddr_in == `PES_STAT_OFS) stat_q <= ev | (stat_q & ~pwdata_in[2:0]);
    else stat_q <= ev | stat_q;
  end

  // level interrupt
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) irq_q <= 1'b0;
    else irq_q <= |(stat_q & mask_q);
  end

  assign prdata_out         = prdata_q;
  assign pready_out         = pready_q;
  assign pslverr_out        = pslverr_q;
  assign serial_data_out    = dout_q;
  assign channel_number_out = num_q;
  assign irq_out            = irq_q;

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_line_preset: assert property (lc_rise && preset |=> lcnt_q == `PES_LINE_PRESET)
    else $error("line counter missed preset");
  a_skip_hold: assert property (wdone && act == slip_skip && !rd_rst |=>
    wr_ptr_q == $past(wr_ptr_q)) else $error("skip moved write pointer");
  a_repeat_two: assert property (wdone && act == slip_repeat && !rd_rst |=>
    wr_ptr_q == (PTR_W+1)'($past(wr_ptr_q) + 2'd2)) else $error("repeat not two entries");
  a_other_pass: assert property (wdone && !wch0 && !rd_rst |=>
    wr_ptr_q == (PTR_W+1)'($past(wr_ptr_q) + 2'd1)) else $error("channel dropped or doubled");
  a_forced_once: assert property (fused && !rd_rst |=> pend_q == slip_none)
    else $error("forced slip pended second frame");
  a_slip_pairs: assert property (wch0 && pend_q == slip_none && act != slip_none
    && !fused && !rd_rst |=> pend_q != slip_none) else $error("slip not paired");
  a_rd_step: assert property (rc_rise && occ != '0 && !rd_rst |=>
    rd_ptr_q == (PTR_W+1)'($past(rd_ptr_q) + 2'd1)) else $error("read counter stuck");
  a_num_fall: assert property ($changed(num_q) |-> $past(rc_fall) || $past(rd_rst))
    else $error("number changed off read clock fall");
  a_dout_rise: assert property ($changed(dout_q) |-> $past(ce_rise) || $past(rd_rst))
    else $error("data changed off exchange edge");
  a_slip_flag: assert property (act != slip_none && !rd_rst |=> slip_ind_q)
    else $error("slip flag not set");

  c_skip:   cover property (wch0 && act == slip_skip);
  c_repeat: cover property (wch0 && act == slip_repeat);
  c_forced: cover property (fused);
  c_insb:   cover property (rc_rise && rent[`PES_E_INSB] && slip_ind_q);
endmodule : pes_elastic_store

// File: hdl/pes_defs.svh
`ifndef PES_DEFS_SVH
`define PES_DEFS_SVH
// register byte offsets
`define PES_CTRL_OFS   8'h00
`define PES_STAT_OFS   8'h04
`define PES_MASK_OFS   8'h08
`define PES_STATE_OFS  8'h0c
// ctrl fields
`define PES_CTRL_FORCE 0
// status and mask fields
`define PES_ST_REPEAT  0
`define PES_ST_SKIP    1
`define PES_ST_FORCED  2
// state register fields
`define PES_SR_OCC     0
`define PES_SR_SLIP    4
`define PES_SR_PEND    8
`define PES_SR_LCNT    16
// reset values
`define PES_MASK_RST   3'h0
// line counter preset: frame a, slot 30, bit 8
`define PES_LINE_PRESET 9'h0f7
// store occupancy: nominal and guard limits, guards two off nominal
// so that two frames of slip land back on nominal
`define PES_NOMINAL    3'h4
`define PES_GUARD_HI   3'h6
`define PES_GUARD_LO   3'h2
// store entry flag positions
`define PES_E_INSA     13
`define PES_E_INSB     14
`endif

// File: hdl/pes_pkg.sv
package pes_pkg;
  // slip action, also the pending second-frame state
  typedef enum logic [1:0] {
    slip_none   = 2'b00,
    slip_repeat = 2'b01,
    slip_skip   = 2'b10
  } pes_slip_e;
  // one store entry: flags, channel number, word
  typedef logic [14:0] pes_entry_t;
endpackage : pes_pkg

// File: dv/pes_far_model.sv
`timescale 1ns/1ns
// far side: line timing source and exchange timing source
module pes_far_model (
  // bench control
  input  var int     ex_half_in,
  // line side
  output logic       line_clock_out,
  output logic       line_data_out,
  output logic       preset_out,
  // exchange side
  output logic       exchange_clock_out,
  output logic       read_clock_out,
  // word on the line, for the bench model
  output logic       sent_out,
  output logic [4:0] sent_ch_out,
  output logic [7:0] sent_word_out
);
  logic [8:0] pos_q = 9'h1ff; // frame, slot, bit
  logic [7:0] frm_q = 8'h00;  // frame count, varies data
  int         ex_n  = 0;      // exchange rises so far
  // recovered clock runs free; data moves on its falling edge
  initial begin
    {line_clock_out, line_data_out, preset_out, sent_out} = 4'h0;
    sent_ch_out = 5'h00;
    sent_word_out = 8'h00;
    forever begin
      #400 line_clock_out = 1'b1;
      #400 line_clock_out = 1'b0;
      pos_q = pos_q + 9'h001;
      if (pos_q == 9'h000) frm_q = frm_q + 8'h01;
      sent_ch_out = pos_q[7:3];
      if (pos_q[7:3] != 5'h00) sent_word_out = frm_q ^ {pos_q[7:3], 3'h5};
      else if (!pos_q[8]) sent_word_out = 8'h1b; // alignment word
      else sent_word_out = 8'h8a; // position 2 low, must be forced
      line_data_out = sent_word_out[3'h7 - pos_q[2:0]]; // msb first
      preset_out = (pos_q == 9'h0f7); // slot 30, position 8
      sent_out = (pos_q[2:0] == 3'h7);
    end
  end
  // eight exchange rises per read period, read rises after the eighth
  initial begin
    exchange_clock_out = 1'b0;
    read_clock_out = 1'b0;
    #130;
    forever begin
      #(ex_half_in) exchange_clock_out = 1'b1;
      ex_n = ex_n + 1;
      #20 read_clock_out = (ex_n % 8 < 4);
      #(ex_half_in - 20) exchange_clock_out = 1'b0;
    end
  end
endmodule : pes_far_model

// File: dv/tb_pes_elastic_store.sv
`timescale 1ns/1ns
`include "pes_defs.svh"
// bench: far model, queue model of the store, apb master
module tb_pes_elastic_store;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, lck, ldat, lpre, eck, rck, sent, dout, irq;
  logic [4:0]  sch, chn;
  logic [7:0]  sword;
  logic        mrst_n = 1'b0;
  logic        fslip = 1'b0;
  logic [6:0]  spare = 7'h00;
  int          ex_half = 400;
  int          num_errors = 0;
  int          n_checks = 0;
  logic [31:0] seed = 32'h149f;
  logic [12:0] q[$];     // channel and word sent, channel 0 left out
  logic [7:0]  sh;       // output bits, msb first
  int          cnt;      // exchange falls since read rise
  logic        on = 1'b0; // monitor enabled
  logic        synced = 1'b0;
  logic        perr;     // error flag of the last apb transfer

  always #50 clk = ~clk;

  pes_elastic_store i_pes_elastic_store (
    .clock_in(clk), .sys_rst_in(rst), .paddr_in(paddr), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .line_clock_in(lck),
    .line_data_in(ldat), .line_counter_preset_in(lpre), .exchange_clock_in(eck),
    .read_clock_in(rck), .master_reset_n_in(mrst_n), .forced_slip_in(fslip),
    .spare_bit_inputs_in(spare), .serial_data_out(dout),
    .channel_number_out(chn), .irq_out(irq));

  pes_far_model i_pes_far_model (
    .ex_half_in(ex_half), .line_clock_out(lck), .line_data_out(ldat),
    .preset_out(lpre), .exchange_clock_out(eck), .read_clock_out(rck),
    .sent_out(sent), .sent_ch_out(sch), .sent_word_out(sword));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // pready ends this wait; if it never comes, the watchdog ends the run
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wf(input int n);
    repeat (n * 2048) @(posedge clk);
  endtask : wf

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  // model side: every line word except channel 0
  always @(posedge sent) if (sch != 5'h00) q.push_back({sch, sword});

  // spares change only while channel 16 goes out, far from slot 0
  always @(posedge clk) begin
    if (chn == 5'h10) begin
      seed = xs(seed);
      spare <= seed[6:0];
    end
  end

  // a word is complete at the first exchange fall after read rise
  always @(posedge rck) cnt = 0;
  always @(negedge eck) begin
    sh = {sh[6:0], dout};
    cnt++;
    if (on && cnt == 1) begin
      if (chn == 5'h00 && !sh[7])
        chk(sh, {2'b00, spare[0], spare[1], spare[2], spare[3], spare[4], spare[5]});
      else if (chn == 5'h00)
        chk({sh[7:5], sh[3:0]}, {2'b11, spare[6], 4'ha});
      else begin
        // before alignment stale words are dropped; later a drop is a fault
        while (!synced && q.size() > 12) void'(q.pop_front());
        while (q.size() > 0 && q[0][12:8] != chn) begin
          if (synced) chk(q[0][12:8], chn);
          void'(q.pop_front());
        end
        synced = 1'b1;
        chk({chn, sh}, (q.size() > 0) ? q.pop_front() : 13'h0);
      end
    end
  end

  initial begin
    #8000000;
    num_errors++;
    give_verdict();
  end

  initial begin
    logic [31:0] r;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    mrst_n <= 1'b1;
    wf(2);
    on = 1'b1;
    apb(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    chk(perr, 1'b1);
    apb(1'b0, `PES_MASK_OFS, 32'h0, r);
    chk(r, 32'h0);
    apb(1'b1, `PES_CTRL_OFS, 32'h1, r);
    wf(2);
    apb(1'b0, `PES_STAT_OFS, 32'h0, r);
    chk(r[2], 1'b1);
    chk(irq, 1'b0);
    apb(1'b1, `PES_MASK_OFS, 32'h4, r);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, `PES_STAT_OFS, 32'h7, r);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    fslip <= 1'b1;
    wf(4);
    fslip <= 1'b0;
    apb(1'b0, `PES_STAT_OFS, 32'h0, r);
    chk(r[2], 1'b1);
    apb(1'b1, `PES_STAT_OFS, 32'h7, r);
    // reads outpace writes: store drains, channel 0 repeats
    ex_half = 396;
    wf(10);
    apb(1'b0, `PES_STAT_OFS, 32'h0, r);
    chk(r[0], 1'b1);
    apb(1'b1, `PES_STAT_OFS, 32'h7, r);
    // writes outpace reads: channel 0 skipped
    ex_half = 404;
    wf(16);
    apb(1'b0, `PES_STAT_OFS, 32'h0, r);
    chk(r[1], 1'b1);
    ex_half = 400;
    on = 1'b0;
    mrst_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({chn, dout}, 6'h00);
    apb(1'b0, `PES_STATE_OFS, 32'h0, r);
    chk(r[3:0], `PES_NOMINAL);
    give_verdict();
  end
endmodule : tb_pes_elastic_store
